// File: tlipm_pkg.sv
// package for the top-level pending and missed-event bookkeeping block
// assumes a 32-bit axi4-lite register bus and word-indexed register offsets
package tlipm_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [15:0] TLIPM_PENDING_IDX = 16'h4600;
  localparam logic [15:0] TLIPM_MISSED_IDX = 16'h4602;
  localparam logic [15:0] TLIPM_ENABLE_IDX = 16'h4604;

  // byte addresses derived from the indices
  localparam logic [19:0] TLIPM_PENDING_ADDR = {2'h0, TLIPM_PENDING_IDX, 2'h0};
  localparam logic [19:0] TLIPM_MISSED_ADDR = {2'h0, TLIPM_MISSED_IDX, 2'h0};
  localparam logic [19:0] TLIPM_ENABLE_ADDR = {2'h0, TLIPM_ENABLE_IDX, 2'h0};

  // bit positions of the sources, same in every register
  localparam int TLIPM_BIT_WATCHDOG = 15;
  localparam int TLIPM_BIT_FAULT = 14;
  localparam int TLIPM_BIT_TIMER = 13;
  localparam int TLIPM_BIT_GPIO = 12;
  localparam int TLIPM_BIT_ADC = 11;
  localparam int TLIPM_BIT_RADIO_RX = 10;
  localparam int TLIPM_BIT_RADIO_TX = 9;
  localparam int TLIPM_BIT_RADIO_TMR = 8;
  localparam int TLIPM_BIT_CRYPTO = 7;
  localparam int TLIPM_BIT_SERIAL_TWO = 6;
  localparam int TLIPM_BIT_SERIAL_ONE = 5;
  localparam int TLIPM_BIT_SLEEP = 4;
  localparam int TLIPM_BIT_BASEBAND = 3;
  localparam int TLIPM_BIT_DEBUG_LINK = 2;
  localparam int TLIPM_BIT_SOFTWARE = 1;

  // bits that exist (bit 0 reads zero)
  localparam logic [15:0] TLIPM_VALID_MASK = 16'hfffe;
  // system-owned bits: application-mode writes are dropped
  localparam logic [15:0] TLIPM_SYSTEM_MASK = 16'hc79e;

  // reset values
  localparam logic [15:0] TLIPM_PENDING_RESET = 16'h0000;
  localparam logic [15:0] TLIPM_MISSED_RESET = 16'h0000;
  localparam logic [15:0] TLIPM_ENABLE_RESET = 16'h0000;

  // axi response codes
  localparam logic [1:0] TLIPM_RESP_OKAY = 2'h0;
  localparam logic [1:0] TLIPM_RESP_SLVERR = 2'h2;

endpackage

// File: tlipm_top.sv
// top-level interrupt pending and missed-event bookkeeping with an axi4-lite slave
// assumes event pulses come from logic on aclk, one cycle wide, no synchroniser needed
// assumes second-level flags and enables are levels on aclk, acknowledged at their own level
// assumes awprot[0] marks system mode; application-mode writes to protected bits vanish
// one aclk domain throughout; reset is taken synchronously with no synchroniser inside
//
// Notes on behaviour
// - fault pending at bit 14; application-mode writes to it are dropped
// - radio receive, transmit, timer pending at bits 10, 9, 8; protected
// - debug link pending bit 2, software trigger bit 1; both protected
// - radio receive, transmit, timer misses at bits 10, 9, 8; protected
// - debug link miss at bit 2; application-mode writes rejected
// - software trigger miss at bit 1; application-mode writes have no effect
// - one-cycle pulse sets pending outside SECOND_LEVEL_MASK; a coinciding clear loses to the set
// - writing one clears that bit only, save second-level pending bits; zeros leave bits alone
// - enabled repeat before acknowledge is dropped and sets the miss bit
// - second-level module bit is or of its flagged and enabled events
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module tlipm_top #(
  parameter int ADDR_W = 20,
  parameter int SL_W = 8,
  parameter logic [15:0] SECOND_LEVEL_MASK = 16'h3060
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // one-cycle event pulses, one per source bit
  input wire logic [15:0] event_pulse,
  // second-level flags and enables, SL_W bits per top-level source
  input wire logic [16*SL_W-1:0] irq_second_level_flags,
  input wire logic [16*SL_W-1:0] irq_second_level_enables,
  // level interrupt to the processor core
  output logic irq_out
);
  import tlipm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte lanes 0 and 1 into a 16-bit write mask
  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // bits software may touch for the given privilege
  function automatic logic [15:0] writable(input logic privileged);
    writable = privileged ? TLIPM_VALID_MASK : (TLIPM_VALID_MASK & ~TLIPM_SYSTEM_MASK);
  endfunction

  // does an address hit the given register word
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [19:0] reg_addr);
    hit = ({addr[ADDR_W-1:2], 2'h0} == ADDR_W'(reg_addr));
  endfunction

  // clear what was acknowledged, then apply new events so a set always wins
  function automatic logic [15:0] ack_then_set(input logic [15:0] cur, input logic [15:0] clr,
                                               input logic [15:0] fresh);
    ack_then_set = ((cur & ~clr) | fresh) & TLIPM_VALID_MASK;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  // software-visible flags and the mask, with their next values
  logic [15:0] pending_q;
  logic [15:0] pending_d;
  logic [15:0] missed_q;
  logic [15:0] missed_d;
  logic [15:0] enable_q;
  logic [15:0] enable_d;

  // register bus: one held write address and data, one response, one read
  logic aw_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic aw_priv_q;
  logic w_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // combinational helpers of the write and event paths
  logic wr_fire;
  logic [15:0] wr_bits;
  logic [15:0] wr_ok;
  logic [15:0] pend_clr;
  logic [15:0] miss_clr;
  logic [15:0] second_level_sum;
  logic [15:0] dropped;
  logic [15:0] wr_clear;
  logic [15:0] wr_lanes;
  // decoded selects, read mux and interrupt next value
  logic aw_sel_pending;
  logic aw_sel_missed;
  logic aw_sel_enable;
  logic aw_mapped;
  logic ar_sel_pending;
  logic ar_sel_missed;
  logic ar_sel_enable;
  logic [15:0] rd_word;
  logic rd_err;
  logic irq_d;

  //////////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order

  // one write under way at a time; both channels stall until the response is taken
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  // the write lands one edge after both halves are held
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

  // held write address against each register word
  assign aw_sel_pending = hit(aw_addr_q, TLIPM_PENDING_ADDR);
  assign aw_sel_missed = hit(aw_addr_q, TLIPM_MISSED_ADDR);
  assign aw_sel_enable = hit(aw_addr_q, TLIPM_ENABLE_ADDR);
  // any other word answers with an error and changes nothing
  assign aw_mapped = aw_sel_pending || aw_sel_missed || aw_sel_enable;

  // the read address is decoded in the cycle it is offered
  assign ar_sel_pending = hit(s_axi_araddr, TLIPM_PENDING_ADDR);
  assign ar_sel_missed = hit(s_axi_araddr, TLIPM_MISSED_ADDR);
  assign ar_sel_enable = hit(s_axi_araddr, TLIPM_ENABLE_ADDR);

  // latch the write address and its privilege
  // awprot counts only here; the data phase carries no privilege
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      aw_priv_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      aw_priv_q <= s_axi_awprot[0];
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  // latch the write data and strobes
  // only lanes 0 and 1 reach a register; the upper half is reserved
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // write response; unmapped addresses answer slverr
  // the response stands until bready, and blocks the next write meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= TLIPM_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= aw_mapped ? TLIPM_RESP_OKAY : TLIPM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  //////////////////////////////////////////////////////////////////////////////
  // write effects

  // awprot[0] low marks application mode, whose writes to system bits vanish
  // protected bits drop out of the mask, so such a write still answers okay
  assign wr_bits = w_data_q[15:0] & lane_mask(w_strb_q);
  assign wr_ok = writable(aw_priv_q);
  assign wr_lanes = lane_mask(w_strb_q) & wr_ok;
  // write-one-to-clear: zeros and refused bits leave their flags alone
  assign wr_clear = wr_bits & wr_ok;
  assign pend_clr = (wr_fire && aw_sel_pending) ? wr_clear : 16'h0000;
  assign miss_clr = (wr_fire && aw_sel_missed) ? wr_clear : 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // second-level summary

  // or of flagged and enabled second-level events per module
  // only bits in SECOND_LEVEL_MASK use this summary; a clear here cannot reach them
  always_comb begin
    second_level_sum = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      second_level_sum[i] = |(irq_second_level_flags[i*SL_W +: SL_W] &
                              irq_second_level_enables[i*SL_W +: SL_W]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pending flags

  // set beats clear so an event landing on the acknowledge is kept
  // a pulse on a second-level bit is overruled by the level summary below
  always_comb begin
    pending_d = ack_then_set(pending_q, pend_clr, event_pulse);
    // second-level bits follow their module; they are cleared down below
    pending_d = (pending_d & ~SECOND_LEVEL_MASK) | (second_level_sum & SECOND_LEVEL_MASK);
    pending_d = pending_d & TLIPM_VALID_MASK;
  end

  // pending flags; reset clears every source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_q <= TLIPM_PENDING_RESET;
    end else begin
      pending_q <= pending_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // missed-event flags

  // no queue: a repeat while pending and not being cleared is lost and logged
  // a masked source may pend many times over without ever logging a miss
  assign dropped = event_pulse & pending_q & ~pend_clr & enable_q;

  // same set-wins rule as the pending flags
  always_comb begin
    missed_d = ack_then_set(missed_q, miss_clr, dropped);
  end

  // missed-event flags; reset clears every source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      missed_q <= TLIPM_MISSED_RESET;
    end else begin
      missed_q <= missed_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // enable mask

  // same layout and protection as the flags; written, not cleared
  always_comb begin
    enable_d = enable_q;
    if (wr_fire && aw_sel_enable) begin
      // bits outside the lanes or refused keep their value; bit 0 stays zero
      enable_d = (enable_q & ~wr_lanes) | (w_data_q[15:0] & wr_lanes);
    end
  end

  // mask register; reset masks every source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= TLIPM_ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt output

  // taken from next-state so the level rises on the same edge as the flag
  assign irq_d = |(pending_d & enable_d);

  // registered so the core sees a glitch-free level from a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi read channel

  // one read under way; answer one cycle after the address is taken
  assign s_axi_arready = !rvalid_q;

  // read mux; the flags are seen as they stand before this edge's events and clears
  // unmapped words read as zero with an error response
  always_comb begin
    rd_word = 16'h0000;
    rd_err = 1'b0;
    if (ar_sel_pending) begin
      rd_word = pending_q;
    end else if (ar_sel_missed) begin
      rd_word = missed_q;
    end else if (ar_sel_enable) begin
      rd_word = enable_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= TLIPM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {16'h0000, rd_word};
      rresp_q <= rd_err ? TLIPM_RESP_SLVERR : TLIPM_RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

`default_nettype wire

// File: tlipm_properties.sv
// checker for the pending and missed-event block
// assumes it is bound to tlipm_top and sees its ports only
`timescale 1ns/10ps
`default_nettype none
module tlipm_properties #(
  parameter int ADDR_W = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_out
);
  import tlipm_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read handshake and whether it hits a register
  wire ar_hit = s_axi_arvalid && s_axi_arready;
  wire ar_map = (s_axi_araddr == TLIPM_PENDING_ADDR) || (s_axi_araddr == TLIPM_MISSED_ADDR)
    || (s_axi_araddr == TLIPM_ENABLE_ADDR);
  wire wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  ////////////////////////////////////////////////////////////////////////////////
  a_b_blocks_req: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_r_blocks_req: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_latency: assert property (ar_hit |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (wr_hit |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles on");
  a_unmapped_read: assert property (ar_hit && !ar_map |=> s_axi_rresp == TLIPM_RESP_SLVERR
    && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_read: assert property (ar_hit && ar_map |=> s_axi_rresp == TLIPM_RESP_OKAY
    && s_axi_rdata[31:16] == 16'h0 && !s_axi_rdata[0])
    else $error("register read has stray bits");
  a_clean_start: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq_out)
    else $error("outputs busy after reset");
  // main scenarios seen
  c_unmapped: cover property (ar_hit && !ar_map);
  c_irq: cover property ($rose(irq_out));
  c_write: cover property (wr_hit);
endmodule
bind tlipm_top tlipm_properties #(.ADDR_W(ADDR_W)) i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_out);
`default_nettype wire

// File: tlipm_event_src.sv
// event source model: one request cycle gives one pulse cycle
// assumes requests change just after the rising edge of aclk
`timescale 1ns/10ps
`default_nettype none
module tlipm_event_src (
  input wire logic aclk,
  input wire logic [15:0] fire,
  output logic [15:0] event_pulse
);
  // registered so each pulse lasts one whole cycle; bit 0 has no source
  always_ff @(posedge aclk) begin
    event_pulse <= fire & 16'hfffe;
  end
endmodule
`default_nettype wire

// File: tlipm_top_test.sv
// self-checking bench for the pending and missed-event block
// assumes tlipm_top, the event source model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tlipm_top_test;
  import tlipm_pkg::*;
  localparam int SL = 8;
  localparam logic [1:0] OK = TLIPM_RESP_OKAY;
  localparam logic [1:0] ERR = TLIPM_RESP_SLVERR;
  // {application may clear, bit}
  localparam logic [4:0] ROWS [11] = '{5'h0f, 5'h0e, 5'h1b, 5'h0a, 5'h09, 5'h08, 5'h07, 5'h04, 5'h03, 5'h02, 5'h01};
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic awr, wrdy, bv, arr, rv, irq;
  logic [2:0] prot = 3'h0;
  logic [19:0] awa = 20'h0, ara = 20'h0;
  logic [15:0] wd = 16'h0, fire = 16'h0, evp;
  logic [16*SL-1:0] slf = {16*SL{1'b0}}, sle = {16*SL{1'b0}};
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  tlipm_top #(.SL_W(SL)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(prot),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata({16'h0, wd}), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .event_pulse(evp), .irq_second_level_flags(slf), .irq_second_level_enables(sle), .irq_out(irq));
  tlipm_event_src i_src (.aclk(aclk), .fire(fire), .event_pulse(evp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // response codes and the interrupt level share the counters above
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  task automatic chk_irq(input logic exp);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  // ready lines are sampled at the edge, before that edge's updates land
  task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic sys, input logic [1:0] er);
    awa <= a;
    wd <= d;
    prot <= {2'h0, sys};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    chk_resp(bresp, er);
  endtask
  task automatic rd(input logic [19:0] a, input logic [15:0] e, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    do @(posedge aclk); while (!rv);
    chk(rdata, {16'h0, e});
    chk_resp(rresp, er);
  endtask
  // the model adds one cycle, so the block sees the pulse two edges on
  task automatic evt(input logic [15:0] b);
    fire <= b;
    @(posedge aclk);
    fire <= 16'h0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, well above the length of the sequence
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    logic [15:0] b, keep;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(TLIPM_PENDING_ADDR, 16'h0, OK);
    rd(TLIPM_MISSED_ADDR, 16'h0, OK);
    wr(TLIPM_ENABLE_ADDR, 16'hffff, 1'b1, OK);
    rd(TLIPM_ENABLE_ADDR, 16'hfffe, OK);
    $display("test reset done");
    foreach (ROWS[i]) begin
      b = 16'h1 << ROWS[i][3:0];
      keep = ROWS[i][4] ? 16'h0 : b;
      evt(b);
      evt(b);
      rd(TLIPM_PENDING_ADDR, b, OK);
      rd(TLIPM_MISSED_ADDR, b, OK);
      chk_irq(1'b1);
      wr(TLIPM_PENDING_ADDR, b, 1'b0, OK);
      wr(TLIPM_MISSED_ADDR, b, 1'b0, OK);
      rd(TLIPM_PENDING_ADDR, keep, OK);
      rd(TLIPM_MISSED_ADDR, keep, OK);
      wr(TLIPM_PENDING_ADDR, b, 1'b1, OK);
      wr(TLIPM_MISSED_ADDR, b, 1'b1, OK);
      chk_irq(1'b0);
    end
    $display("test table done");
    // a new pulse lands on the clearing write; the other bit still clears
    evt(16'h8800);
    fork
      wr(TLIPM_PENDING_ADDR, 16'h8800, 1'b1, OK);
      evt(16'h8000);
    join
    rd(TLIPM_PENDING_ADDR, 16'h8000, OK);
    rd(TLIPM_MISSED_ADDR, 16'h0, OK);
    wr(TLIPM_PENDING_ADDR, 16'h8000, 1'b1, OK);
    $display("test coincide done");
    // masked source: pends but neither interrupts nor counts a miss
    wr(TLIPM_ENABLE_ADDR, 16'h0, 1'b1, OK);
    evt(16'h0800);
    evt(16'h0800);
    chk_irq(1'b0);
    rd(TLIPM_MISSED_ADDR, 16'h0, OK);
    wr(TLIPM_ENABLE_ADDR, 16'h0800, 1'b0, OK);
    chk_irq(1'b1);
    wr(TLIPM_PENDING_ADDR, 16'h0800, 1'b0, OK);
    chk_irq(1'b0);
    $display("test mask done");
    // second level: top bit follows flagged and enabled sub-events
    wr(TLIPM_ENABLE_ADDR, 16'h2000, 1'b1, OK);
    slf[13*SL +: SL] <= 8'h03;
    sle[13*SL +: SL] <= 8'h04;
    repeat (2) @(posedge aclk);
    rd(TLIPM_PENDING_ADDR, 16'h0, OK);
    sle[13*SL +: SL] <= 8'h02;
    repeat (2) @(posedge aclk);
    rd(TLIPM_PENDING_ADDR, 16'h2000, OK);
    chk_irq(1'b1);
    $display("test second level done");
    // mid-run reset with flags, misses and enables set: all return to zero
    sle[13*SL +: SL] <= 8'h00;
    wr(TLIPM_ENABLE_ADDR, 16'h8002, 1'b1, OK);
    evt(16'h8002);
    evt(16'h8002);
    wr(TLIPM_PENDING_ADDR, 16'h0002, 1'b1, OK);
    rd(TLIPM_PENDING_ADDR, 16'h8000, OK);
    rd(TLIPM_MISSED_ADDR, 16'h8002, OK);
    chk_irq(1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(TLIPM_PENDING_ADDR, 16'h0, OK);
    rd(TLIPM_MISSED_ADDR, 16'h0, OK);
    rd(TLIPM_ENABLE_ADDR, 16'h0, OK);
    chk_irq(1'b0);
    $display("test mid reset done");
    rd(20'h00040, 16'h0, ERR);
    wr(20'h00040, 16'hffff, 1'b1, ERR);
    $display("test unmapped done");
    wrap_up;
  end
endmodule
`default_nettype wire
